// ---- logic/rst_seq_map.vh ----
// Constants for the reset and STOP release sequencer.
// Assumes a 10 MHz main clock; included by bare name.
`ifndef RST_SEQ_MAP_VH
`define RST_SEQ_MAP_VH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
// Stabilization time 2^17 periods of the main clock, in ns
`define STAB_TIME_NS 13107200
`define STAB_CYCLES (`STAB_TIME_NS / `CLK_PERIOD_NS)
// Largest select code, which gives the full wait
`define STAB_SEL_MAX 8'h04
// Cycles a watchdog reset holds itself before releasing
`define WDT_HOLD_CYCLES 4

// ****************************************
// Reset vector
// ****************************************
`define RESET_VEC_LO 16'h0000
`define RESET_VEC_HI 16'h0001

// ****************************************
// After-reset register values
// ****************************************
`define PSW_RESET 8'h02
`define PORT_LATCH_RESET 8'h00
`define PORT_DIR_NARROW_RESET 8'h1F
`define PORT_DIR_WIDE_RESET 8'hFF
`define PULLUP_RESET 8'h00
`define PCC_RESET 8'h04
`define STABILIZATION_TIME_SELECT_RESET 8'h04
`define WIDE_TIMER_RESET 16'h0000
`define NARROW_TIMER_RESET 8'h00
`define TIMER_CTRL_RESET 8'h00

`endif

// ---- logic/pin_reset_sync.v ----
// Two-stage synchroniser for the active-low reset pin.
// Assumes the pin is asynchronous to clk; low asserts at once.
`timescale 1ns/1ps
module pin_reset_sync (
  // Clock
  input wire clk,
  // Pin from outside
  input wire pin_n,
  // Synchronised level, low while reset asserted
  output reg pin_sync_n
);

  reg stage_one;

  // ****************************************
  // Assert without clock, release on two edges
  // ****************************************
  // Only the second stage reads stage_one, so a metastable
  // release never reaches the sequencer logic.
  always @(posedge clk or negedge pin_n) begin
    if (!pin_n) begin
      stage_one <= 1'b0;
      pin_sync_n <= 1'b0;
    end else begin
      stage_one <= 1'b1;
      pin_sync_n <= stage_one;
    end
  end

endmodule

// ---- logic/stab_timer.v ----
// Down counter that times the oscillation stabilization wait.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module stab_timer #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire start,
  input wire abort,
  input wire [WIDTH-1:0] length,
  // Status
  output reg busy,
  output reg done
);

  reg [WIDTH-1:0] count;

  // ****************************************
  // Count main clock cycles to terminal count
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst || abort) begin
      count <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count <= length - 1'b1;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && count == {WIDTH{1'b0}}) begin
      busy <= 1'b0;
      done <= 1'b1;
    end else begin
      count <= busy ? count - 1'b1 : count;
      done <= 1'b0;
    end
  end

endmodule

// ---- logic/reset_and_stop_release.v ----
// Reset sequencer: merges pin and watchdog reset, times the
// stabilization wait, ends STOP standby and hands out the
// after-reset values. Assumes CPU, watchdog and interrupt
// flags run on clk; the reset pin is asynchronous.
`timescale 1ns/1ps
`include "rst_seq_map.vh"
module reset_and_stop_release #(
  parameter N_IRQ = 8,
  parameter STAB_CYCLES = `STAB_CYCLES,
  parameter WDT_HOLD = `WDT_HOLD_CYCLES,
  parameter [7:0] MEM_SIZE_RESET = 8'h00,
  parameter [7:0] EXP_RAM_SIZE_RESET = 8'h00
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Reset sources
  input wire reset_pin_n,
  input wire wdt_overflow,
  // STOP entry from the CPU
  input wire stop_enter,
  // Interrupt state
  input wire [N_IRQ-1:0] irq_request,
  input wire [N_IRQ-1:0] irq_mask_flag,
  input wire [N_IRQ-1:0] irq_priority_flag,
  input wire irq_accept_enable,
  input wire in_service_priority,
  // Test input
  input wire test_request,
  input wire test_mask_flag,
  // Stabilization select, as held by the CPU side
  input wire [7:0] stabilization_time_select,
  // CPU control
  output reg cpu_hold,
  output reg stop_mode,
  output reg vector_to_reset,
  output reg vector_to_irq,
  output reg resume_next,
  output reg [15:0] vector_addr_lo,
  output reg [15:0] vector_addr_hi,
  output reg reset_by_watchdog,
  // Pins and oscillators
  output reg pins_high_z,
  output reg main_osc_stop,
  output reg sub_osc_run,
  // Register initialisation
  output reg init_load,
  output reg [7:0] processor_status_word,
  output reg [7:0] port_latch_init,
  output reg [7:0] port_direction_narrow,
  output reg [7:0] port_direction_wide,
  output reg [7:0] pullup_option,
  output reg [7:0] processor_clock_control,
  output reg [7:0] stabilization_select_init,
  output reg [7:0] memory_size_switch,
  output reg [7:0] expansion_ram_size_switch,
  output reg [15:0] wide_timer_count,
  output reg [7:0] wide_timer_clock_select,
  output reg [7:0] wide_timer_mode,
  output reg [7:0] wide_timer_output_ctrl,
  output reg [7:0] narrow_timer_a_count,
  output reg [7:0] narrow_timer_b_count,
  output reg [7:0] narrow_timer_clock_select,
  output reg [7:0] narrow_timer_a_mode,
  output reg [7:0] narrow_timer_b_mode,
  output reg [7:0] narrow_timer_output_ctrl
);

  // ****************************************
  // States, one-hot
  // ****************************************
  localparam [4:0] ST_RESET = 5'b00001;
  localparam [4:0] ST_WAIT = 5'b00010;
  localparam [4:0] ST_RUN = 5'b00100;
  localparam [4:0] ST_STOP = 5'b01000;
  localparam [4:0] ST_STOP_WAIT = 5'b10000;

  localparam TW = 18;
  localparam [TW-1:0] FULL_WAIT = STAB_CYCLES[TW-1:0];

  // Wake kinds latched at STOP release
  localparam [1:0] WAKE_NEXT = 2'b01;
  localparam [1:0] WAKE_IRQ = 2'b10;

  // ****************************************
  // Functions
  // ****************************************
  // Wait length for a select code; each code below the
  // largest halves the wait, so a short STAB_CYCLES scales.
  function [TW-1:0] wait_len;
    input [7:0] sel;
    reg [TW-1:0] len;
    begin
      len = FULL_WAIT;
      if (sel < `STAB_SEL_MAX) begin
        len = FULL_WAIT >> (`STAB_SEL_MAX - sel);
      end
      if (len == {TW{1'b0}}) begin
        len = {{(TW-1){1'b0}}, 1'b1};
      end
      wait_len = len;
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  wire pin_sync_n;
  wire timer_busy;
  wire timer_done;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [7:0] wdt_count;
  reg wdt_active;
  reg [1:0] wake_kind;
  reg timer_start;
  reg [TW-1:0] timer_len;
  wire [N_IRQ-1:0] irq_live;
  wire irq_wake;
  wire irq_high_live;
  wire test_wake;
  wire reset_any;

  // ****************************************
  // Submodules
  // ****************************************
  pin_reset_sync u_pin_sync (
    .clk(clk),
    .pin_n(reset_pin_n),
    .pin_sync_n(pin_sync_n)
  );

  stab_timer #(
    .WIDTH(TW)
  ) u_stab_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(timer_start),
    .abort(reset_any),
    .length(timer_len),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ****************************************
  // Reset sources
  // ****************************************
  // Watchdog reset holds for a few cycles, then frees itself
  always @(posedge clk) begin
    if (sys_rst) begin
      wdt_active <= 1'b0;
      wdt_count <= 8'h00;
    end else if (wdt_overflow) begin
      wdt_active <= 1'b1;
      wdt_count <= WDT_HOLD[7:0];
    end else if (wdt_active) begin
      wdt_count <= wdt_count - 8'h01;
      wdt_active <= (wdt_count > 8'h01);
    end
  end

  // Pin and watchdog merge into one reset
  assign reset_any = !pin_sync_n || wdt_active;

  // ****************************************
  // Wake decoding
  // ****************************************
  // A flag of zero unmasks, and a priority flag of zero is high
  assign irq_live = irq_request & ~irq_mask_flag;
  assign irq_wake = |irq_live;
  assign irq_high_live = |(irq_live & ~irq_priority_flag);
  assign test_wake = test_request && !test_mask_flag;

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    next_state = state;
    timer_start = 1'b0;
    timer_len = FULL_WAIT;
    case (state)
      ST_RESET: begin
        if (!reset_any) begin
          next_state = ST_WAIT;
          timer_start = 1'b1;
          timer_len = FULL_WAIT;
        end
      end
      ST_WAIT: begin
        if (reset_any) begin
          next_state = ST_RESET;
        end else if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (reset_any) begin
          next_state = ST_RESET;
        end else if (stop_enter) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // Reset beats both wake kinds
        if (reset_any) begin
          next_state = ST_RESET;
        end else if (irq_wake || test_wake) begin
          next_state = ST_STOP_WAIT;
          timer_start = 1'b1;
          timer_len = wait_len(stabilization_time_select);
        end
      end
      ST_STOP_WAIT: begin
        if (reset_any) begin
          next_state = ST_RESET;
        end else if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  // ****************************************
  // State register and wake latch
  // ****************************************
  // Vector choice is latched at wake so a flag change during
  // the long wait cannot flip the outcome.
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_RESET;
      wake_kind <= WAKE_NEXT;
    end else begin
      state <= next_state;
      if (state == ST_STOP && next_state == ST_STOP_WAIT) begin
        if (irq_wake && irq_accept_enable &&
            (irq_high_live || in_service_priority)) begin
          wake_kind <= WAKE_IRQ;
        end else begin
          wake_kind <= WAKE_NEXT;
        end
      end
    end
  end

  // ****************************************
  // CPU and pin control outputs
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      cpu_hold <= 1'b1;
      stop_mode <= 1'b0;
      pins_high_z <= 1'b1;
      main_osc_stop <= 1'b1;
      sub_osc_run <= 1'b1;
      reset_by_watchdog <= 1'b0;
    end else begin
      cpu_hold <= (next_state != ST_RUN);
      // STOP stays flagged through a reset that ends it
      if (next_state == ST_STOP) begin
        stop_mode <= 1'b1;
      end else if (next_state == ST_RESET && stop_mode) begin
        stop_mode <= 1'b1;
      end else begin
        stop_mode <= 1'b0;
      end
      pins_high_z <= (next_state == ST_RESET) || (next_state == ST_WAIT);
      main_osc_stop <= (next_state == ST_RESET) || (next_state == ST_STOP);
      sub_osc_run <= 1'b1;
      if (wdt_overflow) begin
        reset_by_watchdog <= 1'b1;
      end else if (!pin_sync_n) begin
        reset_by_watchdog <= 1'b0;
      end
    end
  end

  // ****************************************
  // Resume pulses
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      vector_to_reset <= 1'b0;
      vector_to_irq <= 1'b0;
      resume_next <= 1'b0;
      vector_addr_lo <= `RESET_VEC_LO;
      vector_addr_hi <= `RESET_VEC_HI;
    end else begin
      vector_to_reset <= (state == ST_WAIT) && (next_state == ST_RUN);
      vector_to_irq <= (state == ST_STOP_WAIT) && (next_state == ST_RUN) &&
                       (wake_kind == WAKE_IRQ);
      resume_next <= (state == ST_STOP_WAIT) && (next_state == ST_RUN) &&
                     (wake_kind == WAKE_NEXT);
      vector_addr_lo <= `RESET_VEC_LO;
      vector_addr_hi <= `RESET_VEC_HI;
    end
  end

  // ****************************************
  // After-reset values
  // ****************************************
  // Values are driven constantly; init_load tells the owning
  // registers when to take them. Undefined registers get none.
  always @(posedge clk) begin
    if (sys_rst) begin
      init_load <= 1'b1;
    end else begin
      init_load <= (next_state == ST_RESET);
    end
  end

  always @(posedge clk) begin
    processor_status_word <= `PSW_RESET;
    port_latch_init <= `PORT_LATCH_RESET;
    port_direction_narrow <= `PORT_DIR_NARROW_RESET;
    port_direction_wide <= `PORT_DIR_WIDE_RESET;
    pullup_option <= `PULLUP_RESET;
    processor_clock_control <= `PCC_RESET;
    stabilization_select_init <= `STABILIZATION_TIME_SELECT_RESET;
    memory_size_switch <= MEM_SIZE_RESET;
    expansion_ram_size_switch <= EXP_RAM_SIZE_RESET;
    wide_timer_count <= `WIDE_TIMER_RESET;
    wide_timer_clock_select <= `TIMER_CTRL_RESET;
    wide_timer_mode <= `TIMER_CTRL_RESET;
    wide_timer_output_ctrl <= `TIMER_CTRL_RESET;
    narrow_timer_a_count <= `NARROW_TIMER_RESET;
    narrow_timer_b_count <= `NARROW_TIMER_RESET;
    narrow_timer_clock_select <= `TIMER_CTRL_RESET;
    narrow_timer_a_mode <= `TIMER_CTRL_RESET;
    narrow_timer_b_mode <= `TIMER_CTRL_RESET;
    narrow_timer_output_ctrl <= `TIMER_CTRL_RESET;
  end

endmodule

// ---- verif/reset_and_stop_release_checker.sv ----
// Assertions for the reset and STOP release sequencer.
// Assumes one clock, clk, and sys_rst synchronous active high.
`timescale 1ns/1ps
module reset_and_stop_release_checker #(
  parameter N_IRQ = 8,
  parameter STAB_CYCLES = 131072
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sources
  input wire logic reset_pin_n,
  input wire logic wdt_overflow,
  input wire logic stop_enter,
  input wire logic [N_IRQ-1:0] irq_request,
  input wire logic [N_IRQ-1:0] irq_mask_flag,
  input wire logic test_request,
  input wire logic test_mask_flag,
  // CPU side
  input wire logic cpu_hold,
  input wire logic stop_mode,
  input wire logic vector_to_reset,
  input wire logic vector_to_irq,
  input wire logic resume_next,
  input wire logic [15:0] vector_addr_lo,
  input wire logic [15:0] vector_addr_hi,
  // Pins, oscillators, values
  input wire logic pins_high_z,
  input wire logic main_osc_stop,
  input wire logic sub_osc_run,
  input wire logic init_load,
  input wire logic [7:0] processor_status_word,
  input wire logic [7:0] port_latch_init,
  input wire logic [7:0] port_direction_narrow,
  input wire logic [7:0] port_direction_wide
);
  // ****************************************
  // Wait length counter
  // ****************************************
  // A repetition cannot span the real wait, so count it
  localparam int WMIN = STAB_CYCLES - 1;
  localparam int WMAX = STAB_CYCLES + 4;
  logic [19:0] wait_cnt;
  always_ff @(posedge clk) begin
    if (sys_rst || !pins_high_z || init_load) begin
      wait_cnt <= '0;
    end else begin
      wait_cnt <= wait_cnt + 20'd1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence stop_req_s;
    stop_enter && !cpu_hold && reset_pin_n && !wdt_overflow;
  endsequence
  sequence stop_held_s;
    stop_mode && cpu_hold && main_osc_stop;
  endsequence

  pin_reset_a: assert property (
    !reset_pin_n |-> ##[0:3] (cpu_hold && pins_high_z && main_osc_stop)) else $error("pin reset not applied");
  wdt_reset_a: assert property (
    wdt_overflow && !cpu_hold |-> ##[1:3] (cpu_hold && pins_high_z)) else $error("watchdog reset not applied");
  stop_entry_a: assert property (
    stop_req_s |=> stop_held_s) else $error("stop not entered");
  reset_in_stop_a: assert property (
    stop_mode && !reset_pin_n |=> stop_mode) else $error("stop state lost in reset");
  masked_hold_a: assert property (
    stop_mode && !pins_high_z && reset_pin_n && ((irq_request & ~irq_mask_flag) == '0)
    && !(test_request && !test_mask_flag) |=> stop_mode) else $error("masked source ended stop");
  reset_wait_a: assert property (
    vector_to_reset |-> wait_cnt inside {[WMIN:WMAX]} && !pins_high_z && !cpu_hold) else $error("reset wait wrong");
  vector_addr_a: assert property (
    vector_to_reset |-> vector_addr_lo == 16'h0000 && vector_addr_hi == 16'h0001) else $error("vector address wrong");
  wake_pulse_a: assert property (
    (vector_to_irq || resume_next) |-> !cpu_hold && !(vector_to_irq && resume_next)
    ##1 !vector_to_irq && !resume_next) else $error("wake pulse wrong");
  init_values_a: assert property (
    init_load |-> processor_status_word == 8'h02 && port_latch_init == 8'h00
    && port_direction_narrow == 8'h1f && port_direction_wide == 8'hff) else $error("init values wrong");
  sub_osc_a: assert property (
    sub_osc_run) else $error("subsystem oscillator stopped");
endmodule

// ---- verif/wdt_cpu_model.sv ----
// Watchdog and CPU stand-in: makes overflow and STOP pulses.
// Assumes the sequencer samples on the rising edge of clk.
`timescale 1ns/1ps
module wdt_cpu_model (
  // Clock
  input wire logic clk,
  // Towards the sequencer
  output logic wdt_overflow,
  output logic stop_enter
);
  initial begin
    wdt_overflow = 1'b0;
    stop_enter = 1'b0;
  end
  // One-cycle overflow, launched off the falling edge
  task automatic overflow();
    @(negedge clk);
    wdt_overflow = 1'b1;
    @(negedge clk);
    wdt_overflow = 1'b0;
  endtask
  // STOP instruction executed, one cycle wide
  task automatic exec_stop();
    @(negedge clk);
    stop_enter = 1'b1;
    @(negedge clk);
    stop_enter = 1'b0;
  endtask
endmodule

// ---- verif/test_reset_and_stop_release.sv ----
// Testbench for the reset and STOP release sequencer.
// Assumes a 10 MHz clock and a shortened stabilization count.
`timescale 1ns/1ps
module test_reset_and_stop_release;
  localparam int N_IRQ = 8;
  localparam int STAB_CYCLES = 16;
  localparam int WDT_HOLD = 4;
  logic clk, sys_rst, reset_pin_n, wdt_overflow, stop_enter, irq_accept_enable, in_service_priority;
  logic test_request, test_mask_flag, cpu_hold, stop_mode, vector_to_reset, vector_to_irq, resume_next;
  logic reset_by_watchdog, pins_high_z, main_osc_stop, sub_osc_run, init_load;
  logic [N_IRQ-1:0] irq_request, irq_mask_flag, irq_priority_flag;
  logic [15:0] vector_addr_lo, vector_addr_hi, wide_timer_count;
  logic [7:0] stabilization_time_select, processor_status_word, port_latch_init, port_direction_narrow;
  logic [7:0] port_direction_wide, pullup_option, processor_clock_control, stabilization_select_init;
  logic [7:0] memory_size_switch, expansion_ram_size_switch, wide_timer_clock_select, wide_timer_mode;
  logic [7:0] wide_timer_output_ctrl, narrow_timer_a_count, narrow_timer_b_count, narrow_timer_clock_select;
  logic [7:0] narrow_timer_a_mode, narrow_timer_b_mode, narrow_timer_output_ctrl;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  // Wake cases: source, mask, priority, enable, in-service
  logic [4:0] cs [0:7] = '{5'b00000, 5'b00010, 5'b00101, 5'b00110, 5'b00111, 5'b01011, 5'b10010, 5'b11010};
  // Outcome: 1 vector, 2 next instruction, 3 stays in STOP
  int ex [0:7] = '{2, 1, 2, 2, 1, 3, 2, 3};

  // Size switch values stand in for one product's constants
  reset_and_stop_release #(.N_IRQ(N_IRQ), .STAB_CYCLES(STAB_CYCLES), .WDT_HOLD(WDT_HOLD),
    .MEM_SIZE_RESET(8'h12), .EXP_RAM_SIZE_RESET(8'h34)) uut (
    .clk, .sys_rst, .reset_pin_n, .wdt_overflow, .stop_enter, .irq_request, .irq_mask_flag,
    .irq_priority_flag, .irq_accept_enable, .in_service_priority, .test_request, .test_mask_flag,
    .stabilization_time_select, .cpu_hold, .stop_mode, .vector_to_reset, .vector_to_irq, .resume_next,
    .vector_addr_lo, .vector_addr_hi, .reset_by_watchdog, .pins_high_z, .main_osc_stop, .sub_osc_run,
    .init_load, .processor_status_word, .port_latch_init, .port_direction_narrow, .port_direction_wide,
    .pullup_option, .processor_clock_control, .stabilization_select_init, .memory_size_switch,
    .expansion_ram_size_switch, .wide_timer_count, .wide_timer_clock_select, .wide_timer_mode,
    .wide_timer_output_ctrl, .narrow_timer_a_count, .narrow_timer_b_count, .narrow_timer_clock_select,
    .narrow_timer_a_mode, .narrow_timer_b_mode, .narrow_timer_output_ctrl);
  wdt_cpu_model model (.clk, .wdt_overflow, .stop_enter);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for one pulse: 0 reset vector, 1 interrupt, 2 next
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clk);
      #1;
      cnt++;
      hit = (sel == 0) ? (vector_to_reset === 1'b1) : (sel == 1) ? (vector_to_irq === 1'b1) : (resume_next === 1'b1);
      if (!hit && cnt >= lim) begin
        miscompares++;
        $display("MISMATCH at %0t: pulse %0d never came", $time, sel);
        results();
      end
    end
  endtask
  task automatic enter_stop();
    model.exec_stop();
    @(negedge clk);
    check({stop_mode, cpu_hold, main_osc_stop}, 3'b111, "stop entry");
  endtask

  // ****************************************
  // Clock and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {sys_rst, reset_pin_n} = 2'b11;
    {test_request, test_mask_flag, irq_accept_enable, in_service_priority} = 4'b0100;
    irq_request = '0;
    irq_mask_flag = '1;
    irq_priority_flag = '1;
    stabilization_time_select = 8'h04;
    repeat (6) @(negedge clk);
    check(processor_status_word, 8'h02, "status word");
    check({port_latch_init, port_direction_narrow}, 16'h001f, "latch, narrow dir");
    check({port_direction_wide, pullup_option}, 16'hff00, "wide dir, pull-up");
    check({processor_clock_control, stabilization_select_init}, 16'h0404, "clock ctrl, select");
    check({memory_size_switch, expansion_ram_size_switch}, 16'h1234, "size switches");
    check(wide_timer_count, 16'h0000, "wide count");
    check({wide_timer_clock_select, wide_timer_mode, wide_timer_output_ctrl}, 16'h0000, "wide ctrl");
    check({narrow_timer_a_count, narrow_timer_b_count}, 16'h0000, "narrow counts");
    check({narrow_timer_clock_select, narrow_timer_a_mode}, 16'h0000, "narrow ctrl");
    check({narrow_timer_b_mode, narrow_timer_output_ctrl}, 16'h0000, "narrow ctrl b");
    check({init_load, main_osc_stop, sub_osc_run, pins_high_z}, 4'b1111, "reset outputs");
    sys_rst = 1'b0;
    wait_for(0, STAB_CYCLES + 10, n);
    check(n >= STAB_CYCLES && n <= STAB_CYCLES + 6, 1'b1, "power-up wait");
    $display("test power_up done");
    // Pin reset, held well past the synchroniser
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    check({cpu_hold, pins_high_z, main_osc_stop, sub_osc_run, init_load}, 5'b11111, "pin reset");
    reset_pin_n = 1'b1;
    wait_for(0, STAB_CYCLES + 10, n);
    check(n >= STAB_CYCLES && n <= STAB_CYCLES + 6, 1'b1, "pin wait");
    check({vector_addr_lo, vector_addr_hi}, 32'h0000_0001, "vector");
    check({pins_high_z, cpu_hold, reset_by_watchdog, init_load}, 4'b0000, "pin release");
    $display("test pin_reset done");
    // Watchdog reset releases itself
    model.overflow();
    wait_for(0, WDT_HOLD + STAB_CYCLES + 10, n);
    check(n >= WDT_HOLD + STAB_CYCLES - 1 && n <= WDT_HOLD + STAB_CYCLES + 6, 1'b1, "wdt wait");
    check({reset_by_watchdog, pins_high_z}, 2'b10, "wdt cause");
    $display("test watchdog done");
    // STOP release table
    for (int i = 0; i < 8; i++) begin
      enter_stop();
      irq_accept_enable = cs[i][1];
      in_service_priority = cs[i][0];
      if (cs[i][4]) begin
        test_mask_flag = cs[i][3];
        test_request = 1'b1;
      end else begin
        irq_mask_flag[2] = cs[i][3];
        irq_priority_flag[2] = cs[i][2];
        irq_request[2] = 1'b1;
      end
      if (ex[i] == 3) begin
        repeat (STAB_CYCLES + 4) @(negedge clk);
        check(stop_mode, 1'b1, "masked wake");
        test_mask_flag = 1'b0;
        test_request = 1'b1;
      end
      wait_for((ex[i] == 1) ? 1 : 2, STAB_CYCLES + 10, n);
      check(n >= STAB_CYCLES, 1'b1, "stop wait");
      check({stop_mode, cpu_hold, main_osc_stop}, 3'b000, "stop left");
      @(negedge clk);
      {test_request, test_mask_flag, irq_request, irq_mask_flag} = {2'b01, {N_IRQ{1'b0}}, {N_IRQ{1'b1}}};
    end
    $display("test stop_release done");
    // Short select code: a test wake waits a quarter of the full count
    stabilization_time_select = 8'h02;
    enter_stop();
    {test_request, test_mask_flag} = 2'b10;
    wait_for(2, STAB_CYCLES + 10, n);
    check(n, STAB_CYCLES / 4 + 2, "short select wait");
    @(negedge clk);
    {test_request, test_mask_flag} = 2'b01;
    $display("test short_select done");
    // Reset arriving in STOP; the short select must not shorten its wait
    enter_stop();
    reset_pin_n = 1'b0;
    repeat (5) @(negedge clk);
    check({stop_mode, pins_high_z}, 2'b11, "stop held in reset");
    reset_pin_n = 1'b1;
    wait_for(0, STAB_CYCLES + 10, n);
    check(n >= STAB_CYCLES, 1'b1, "stop reset wait");
    check({stop_mode, pins_high_z}, 2'b00, "reset after stop");
    $display("test stop_reset done");
    results();
  end
endmodule

bind reset_and_stop_release reset_and_stop_release_checker #(.N_IRQ(N_IRQ), .STAB_CYCLES(STAB_CYCLES)) chk (
  .clk, .sys_rst, .reset_pin_n, .wdt_overflow, .stop_enter, .irq_request, .irq_mask_flag, .test_request,
  .test_mask_flag, .cpu_hold, .stop_mode, .vector_to_reset, .vector_to_irq, .resume_next, .vector_addr_lo,
  .vector_addr_hi, .pins_high_z, .main_osc_stop, .sub_osc_run, .init_load, .processor_status_word,
  .port_latch_init, .port_direction_narrow, .port_direction_wide);
